// ### acsp_host.sv
// host end of the converter's three-wire configuration port
// assumes a plain register port from software and one device on the pins
// Contract
// - transfers only while chip select low
// - frame starts first clock rise after select
// - select held low streams successive bytes
// - select may rise between bytes, frame resumes
// - sixteen-bit instruction opens every frame
// - data moves as eight-bit words
// - clock, select in; data pin two-way
// - write zeros to unused register bits; the host clears them only in the port config byte
// - never write fully open addresses; only the start address is refused, streamed bytes are not checked
// - keep port quiet during critical sampling; hold_off_i only holds back frame starts, a running frame goes on
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module acsp_host #(
    parameter int unsigned SCLK_HALF = acsp_pkg::SCLK_HALF_CYC,
    parameter int unsigned STALL_LEN = acsp_pkg::STALL_CYC
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_i,
    input  wire logic [acsp_pkg::HR_AW-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [31:0]                reg_rdata_o,
    input  wire logic                       hold_off_i,
    output logic                            chip_select_n_o,
    output logic                            serial_clock_o,
    output logic                            serial_data_o,
    output logic                            serial_data_oe_o,
    input  wire logic                       serial_data_i
);
    import acsp_pkg::*;

    typedef struct packed {
        acsp_state_t st;
        logic        cs_n;
        logic        sdo;
        logic        oe;
        logic [4:0]  bit_cnt;
        logic [1:0]  byte_cnt;
        logic [15:0] sh;
        logic [7:0]  rx;
        logic [7:0]  wait_cnt;
        logic        rd;
        logic [1:0]  len;
        logic        stall_en;
        logic [12:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        done;
        logic        refused;
        logic        lsb;
        logic        pending;
        logic [31:0] rd_out;
    } acsp_host_t;

    // reset assumes the device is back at its defaults: msb first
    localparam acsp_host_t Q_RST = '{st: S_IDLE, cs_n: 1'b1, default: '0};

    acsp_host_t q_reg;
    acsp_host_t q_next;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sdi_s;
    logic       run;

    function automatic logic pick(input logic [15:0] s, input logic lsb);
        return lsb ? s[0] : s[15];
    endfunction : pick

    function automatic logic [15:0] shift(input logic [15:0] s, input logic lsb);
        return lsb ? {1'b0, s[15:1]} : {s[14:0], 1'b0};
    endfunction : shift

    // mirrored layout forced so either bit order lands the same bits
    function automatic logic [7:0] tidy(input logic [12:0] a, input logic [7:0] b);
        logic [7:0] t;
        t = b;
        if (a == DEV_SERIAL_PORT_CONFIG) begin
            t = 8'h00;
            t[SPC_LSB_HI]  = b[SPC_LSB_HI] | b[SPC_LSB_LO];
            t[SPC_LSB_LO]  = b[SPC_LSB_HI] | b[SPC_LSB_LO];
            t[SPC_SRST_HI] = b[SPC_SRST_HI] | b[SPC_SRST_LO];
            t[SPC_SRST_LO] = b[SPC_SRST_HI] | b[SPC_SRST_LO];
            t[SPC_ONE_HI]  = 1'b1;
            t[SPC_ONE_LO]  = 1'b1;
        end
        return t;
    endfunction : tidy

    function automatic logic [15:0] load_byte(input logic [7:0] b, input logic lsb);
        return lsb ? {8'h00, b} : {b, 8'h00};
    endfunction : load_byte

    function automatic logic is_open(input logic [12:0] a);
        return (a > DEV_CHIP_CFG_LAST && a < DEV_CHAN_INDEX)
            || (a > DEV_CHAN_INDEX && a < DEV_FUNC_FIRST)
            || (a == DEV_OPEN_LOC)
            || (a > DEV_FUNC_LAST && a != DEV_TRANSFER);
    endfunction : is_open

    assign run = (q_reg.st == S_INSTR) || (q_reg.st == S_DATA);

    acsp_sclk_gen #(
        .HALF (SCLK_HALF)
    ) u_sclk (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (run),
        .sclk_o    (serial_clock_o),
        .rise_o    (sclk_rise),
        .fall_o    (sclk_fall)
    );

    acsp_sync u_sdi_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   (serial_data_i),
        .sync_o    (sdi_s)
    );

    always_comb begin
        logic [7:0]  rx_n;
        logic [7:0]  nb;
        logic [15:0] ins;
        logic [15:0] sh_n;
        logic [31:0] sts;
        rx_n = 8'h00;
        nb   = 8'h00;
        ins  = 16'h0000;
        sh_n = 16'h0000;
        sts  = 32'h0000_0000;
        sts[STS_BUSY]    = (q_reg.st != S_IDLE) || q_reg.pending;
        sts[STS_DONE]    = q_reg.done;
        sts[STS_REFUSED] = q_reg.refused;
        sts[STS_LSB]     = q_reg.lsb;
        q_next        = q_reg;
        q_next.rd_out = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                HR_CTRL:   q_next.rd_out = {27'h0, q_reg.stall_en, q_reg.len, q_reg.rd, 1'b0};
                HR_ADDR:   q_next.rd_out = {19'h0, q_reg.addr};
                HR_WDATA:  q_next.rd_out = q_reg.wdata;
                HR_RDATA:  q_next.rd_out = q_reg.rdata;
                HR_STATUS: q_next.rd_out = sts;
                default:   q_next.rd_out = 32'h0000_0000;
            endcase
        end
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                HR_ADDR:  q_next.addr  = reg_wdata_i[12:0];
                HR_WDATA: q_next.wdata = reg_wdata_i;
                HR_STATUS: begin
                    if (reg_wdata_i[STS_DONE]) begin
                        q_next.done = 1'b0;
                    end
                    if (reg_wdata_i[STS_REFUSED]) begin
                        q_next.refused = 1'b0;
                    end
                end
                HR_CTRL: begin
                    if (sts[STS_BUSY]) begin
                        q_next.refused = 1'b1;
                    end else begin
                        q_next.rd       = reg_wdata_i[CTL_READ];
                        q_next.len      = reg_wdata_i[CTL_LEN_HI:CTL_LEN_LO];
                        q_next.stall_en = reg_wdata_i[CTL_STALL];
                        if (reg_wdata_i[CTL_GO]) begin
                            if (!reg_wdata_i[CTL_READ] && is_open(q_reg.addr)) begin
                                q_next.refused = 1'b1;
                            end else begin
                                q_next.pending = 1'b1;
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
        // the state machine follows the port writes so its flag sets win
        unique case (q_reg.st)
            S_IDLE: begin
                // pending frames wait while the converter needs a quiet port
                if (q_reg.pending && !hold_off_i) begin
                    ins = {q_reg.rd, q_reg.len, q_reg.addr};
                    q_next.pending  = 1'b0;
                    q_next.st       = S_INSTR;
                    q_next.cs_n     = 1'b0;
                    q_next.oe       = 1'b1;
                    q_next.sh       = ins;
                    q_next.sdo      = pick(ins, q_reg.lsb);
                    q_next.bit_cnt  = 5'd0;
                    q_next.byte_cnt = 2'd0;
                end
            end
            S_INSTR: begin
                if (sclk_rise) begin
                    q_next.bit_cnt = q_reg.bit_cnt + 5'd1;
                end
                if (sclk_fall) begin
                    if (q_reg.bit_cnt == 5'(INSTR_BITS)) begin
                        q_next.st      = S_DATA;
                        q_next.bit_cnt = 5'd0;
                        if (q_reg.rd) begin
                            q_next.oe  = 1'b0;
                            q_next.sdo = 1'b0;
                        end else begin
                            nb = tidy(q_reg.addr, q_reg.wdata[7:0]);
                            sh_n = load_byte(nb, q_reg.lsb);
                            q_next.sh  = sh_n;
                            q_next.sdo = pick(sh_n, q_reg.lsb);
                        end
                    end else begin
                        sh_n = shift(q_reg.sh, q_reg.lsb);
                        q_next.sh  = sh_n;
                        q_next.sdo = pick(sh_n, q_reg.lsb);
                    end
                end
            end
            S_DATA: begin
                if (sclk_rise) begin
                    q_next.bit_cnt = q_reg.bit_cnt + 5'd1;
                    if (q_reg.rd) begin
                        rx_n = q_reg.lsb ? {sdi_s, q_reg.rx[7:1]} : {q_reg.rx[6:0], sdi_s};
                        q_next.rx = rx_n;
                        if (q_reg.bit_cnt == 5'(BYTE_BITS - 1)) begin
                            q_next.rdata[{q_reg.byte_cnt, 3'b000} +: 8] = rx_n;
                        end
                    end
                end
                if (sclk_fall) begin
                    if (q_reg.bit_cnt == 5'(BYTE_BITS)) begin
                        if (q_reg.byte_cnt == q_reg.len) begin
                            q_next.st       = S_FINISH;
                            q_next.oe       = 1'b0;
                            q_next.sdo      = 1'b0;
                            q_next.wait_cnt = 8'h00;
                        end else begin
                            // the device steps its own address between bytes
                            q_next.byte_cnt = q_reg.byte_cnt + 2'd1;
                            q_next.bit_cnt  = 5'd0;
                            if (!q_reg.rd) begin
                                nb = q_reg.wdata[{q_reg.byte_cnt + 2'd1, 3'b000} +: 8];
                                sh_n = load_byte(nb, q_reg.lsb);
                                q_next.sh  = sh_n;
                                q_next.sdo = pick(sh_n, q_reg.lsb);
                            end
                            if (q_reg.stall_en) begin
                                q_next.st       = S_STALL;
                                q_next.cs_n     = 1'b1;
                                q_next.wait_cnt = 8'h00;
                            end
                        end
                    end else if (!q_reg.rd) begin
                        sh_n = shift(q_reg.sh, q_reg.lsb);
                        q_next.sh  = sh_n;
                        q_next.sdo = pick(sh_n, q_reg.lsb);
                    end
                end
            end
            S_STALL: begin
                q_next.wait_cnt = q_reg.wait_cnt + 8'h01;
                if (q_reg.wait_cnt == 8'(STALL_LEN - 1)) begin
                    q_next.st   = S_DATA;
                    q_next.cs_n = 1'b0;
                end
            end
            S_FINISH: begin
                q_next.wait_cnt = q_reg.wait_cnt + 8'h01;
                if (q_reg.wait_cnt == 8'(SCLK_HALF - 1)) begin
                    q_next.st   = S_IDLE;
                    q_next.cs_n = 1'b1;
                    q_next.done = 1'b1;
                    // track the device's bit order from what was written to it
                    if (!q_reg.rd && q_reg.addr == DEV_SERIAL_PORT_CONFIG) begin
                        nb = tidy(q_reg.addr, q_reg.wdata[7:0]);
                        q_next.lsb = nb[SPC_SRST_HI] ? 1'b0 : nb[SPC_LSB_HI];
                    end
                end
            end
            default: begin
                q_next.st   = S_IDLE;
                q_next.cs_n = 1'b1;
                q_next.oe   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q_reg <= Q_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    assign reg_rdata_o      = q_reg.rd_out;
    assign chip_select_n_o  = q_reg.cs_n;
    assign serial_data_o    = q_reg.sdo;
    assign serial_data_oe_o = q_reg.oe;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_cs_gates_clk: assert property (serial_clock_o |-> !chip_select_n_o)
        else $error("serial clock high while chip select is high");

    a_frame_start: assert property (
        $fell(chip_select_n_o) |-> (!serial_clock_o)[*4] ##1 serial_clock_o)
        else $error("first clock rise not four cycles after select fell");

    a_stream_hold: assert property (
        (q_reg.st == S_DATA && !q_reg.stall_en) |-> !chip_select_n_o)
        else $error("select left low streaming frame");

    a_stall_high: assert property (
        (q_reg.st == S_STALL) |-> chip_select_n_o && !serial_clock_o)
        else $error("stall without select high");

    a_instr_bits: assert property (
        (q_reg.st == S_INSTR && q_next.st == S_DATA) |-> q_reg.bit_cnt == 5'd16)
        else $error("instruction not sixteen bits");

    a_byte_bits: assert property (
        (q_reg.st != S_IDLE && q_reg.st != S_INSTR && $changed(q_reg.byte_cnt))
        |-> $past(q_reg.bit_cnt) == 5'd8)
        else $error("byte boundary not after eight bits");

    a_read_turn: assert property (
        (q_reg.st == S_DATA && q_reg.rd) |-> !serial_data_oe_o)
        else $error("host drives data pin during readback");

    a_instr_drive: assert property (
        (q_reg.st == S_INSTR) |-> serial_data_oe_o)
        else $error("data pin not driven during instruction");

    a_idle_release: assert property (
        (q_reg.st == S_IDLE) |-> chip_select_n_o && !serial_data_oe_o)
        else $error("pins held while idle");

    a_first_bit: assert property (
        (q_reg.st == S_IDLE && q_next.st == S_INSTR)
        |=> serial_data_o == ($past(q_reg.lsb) ? $past(q_reg.addr[0]) : $past(q_reg.rd)))
        else $error("first instruction bit wrong");

    a_open_refused: assert property (
        (reg_wr_i && reg_addr_i == HR_CTRL && reg_wdata_i[CTL_GO] && !reg_wdata_i[CTL_READ]
         && is_open(q_reg.addr) && q_reg.st == S_IDLE && !q_reg.pending)
        |=> q_reg.refused && !q_reg.pending)
        else $error("write to open address not refused");

    c_write_done: cover property ((q_reg.st == S_FINISH && !q_reg.rd) ##1 q_reg.done);
    c_read_done:  cover property (q_reg.st == S_FINISH && q_reg.rd && q_reg.len == 2'd1);
    c_stall:      cover property (q_reg.st == S_STALL ##[1:20] q_reg.st == S_DATA);
    c_lsb_mode:   cover property ($rose(q_reg.lsb));
endmodule : acsp_host
`default_nettype wire

// ### acsp_pkg.sv
// constants for the host end of the converter's three-wire configuration port
// assumes a 10 MHz system clock and a device that samples on the rising serial clock
package acsp_pkg;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SCLK_HALF_NS  = 400;
    localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STALL_NS      = 800;
    localparam int unsigned STALL_CYC     = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // frame shape
    localparam int unsigned INSTR_BITS = 16;
    localparam int unsigned BYTE_BITS  = 8;
    localparam int unsigned DEV_AW     = 13;
    localparam int unsigned INS_RW_BIT = 15;
    localparam int unsigned INS_LEN_HI = 14;
    localparam int unsigned INS_LEN_LO = 13;

    // device register map
    localparam logic [12:0] DEV_SERIAL_PORT_CONFIG    = 13'h0000;
    localparam logic [12:0] DEV_CHIP_CFG_LAST         = 13'h0002;
    localparam logic [12:0] DEV_CHAN_INDEX            = 13'h0005;
    localparam logic [12:0] DEV_FUNC_FIRST            = 13'h0008;
    localparam logic [12:0] DEV_OPEN_LOC              = 13'h0013;
    localparam logic [12:0] DEV_OUTPUT_FORMAT_CONTROL = 13'h0014;
    localparam logic [12:0] DEV_FUNC_LAST             = 13'h003A;
    localparam logic [12:0] DEV_TRANSFER              = 13'h00FF;
    localparam logic [7:0]  SPC_RESET                 = 8'h18;
    localparam logic [7:0]  OFC_RESET                 = 8'h05;
    localparam logic [7:0]  TRANSFER_GO               = 8'h01;
    localparam int unsigned SPC_LSB_HI  = 6;
    localparam int unsigned SPC_LSB_LO  = 1;
    localparam int unsigned SPC_SRST_HI = 5;
    localparam int unsigned SPC_SRST_LO = 2;
    localparam int unsigned SPC_ONE_HI  = 4;
    localparam int unsigned SPC_ONE_LO  = 3;

    // host command port
    localparam int unsigned HR_AW     = 3;
    localparam logic [2:0]  HR_CTRL   = 3'h0;
    localparam logic [2:0]  HR_ADDR   = 3'h1;
    localparam logic [2:0]  HR_WDATA  = 3'h2;
    localparam logic [2:0]  HR_RDATA  = 3'h3;
    localparam logic [2:0]  HR_STATUS = 3'h4;
    localparam int unsigned CTL_GO     = 0;
    localparam int unsigned CTL_READ   = 1;
    localparam int unsigned CTL_LEN_LO = 2;
    localparam int unsigned CTL_LEN_HI = 3;
    localparam int unsigned CTL_STALL  = 4;
    localparam int unsigned STS_BUSY    = 0;
    localparam int unsigned STS_DONE    = 1;
    localparam int unsigned STS_REFUSED = 2;
    localparam int unsigned STS_LSB     = 3;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_INSTR  = 3'b001,
        S_DATA   = 3'b010,
        S_STALL  = 3'b011,
        S_FINISH = 3'b100
    } acsp_state_t;

endpackage : acsp_pkg

// ### acsp_sync.sv
// two-flop synchroniser for the returning serial data pin
// assumes the input is asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module acsp_sync (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } acsp_sync_t;

    acsp_sync_t sync_reg;
    acsp_sync_t sync_next;

    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = async_i;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg.s2;
endmodule : acsp_sync
`default_nettype wire

// ### acsp_sclk_gen.sv
// serial clock divider: idles low, rises HALF cycles after run goes high
// assumes run_i is a registered level from the same clock
`timescale 1ns/1ps
`default_nettype none
module acsp_sclk_gen #(
    parameter int unsigned HALF = 4
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      sclk_o,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       lvl;
    } acsp_div_t;

    acsp_div_t div_reg;
    acsp_div_t div_next;
    logic      wrap;

    assign wrap = (div_reg.cnt == 8'(HALF - 1));

    always_comb begin
        div_next = div_reg;
        if (!run_i) begin
            div_next = '0;
        end else if (wrap) begin
            div_next.cnt = 8'h00;
            div_next.lvl = !div_reg.lvl;
        end else begin
            div_next.cnt = div_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign sclk_o = div_reg.lvl;
    assign rise_o = run_i && wrap && !div_reg.lvl;
    assign fall_o = run_i && wrap && div_reg.lvl;
endmodule : acsp_sclk_gen
`default_nettype wire

// ### acsp_dev_model.sv
// behavioural converter behind the three-wire configuration port
// assumes select and serial clock come from the host, data wire resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module acsp_dev_model (
    input  wire logic cs_n_i,
    input  wire logic sclk_i,
    input  wire logic sdio_i,
    output logic      drv_o,
    output logic      sd_o
);
    logic [7:0]  mem [0:255];
    logic [15:0] ins;
    logic [7:0]  sh;
    logic [7:0]  adr;
    logic        lsb;
    logic        drv;
    int          cnt;
    int          nb;
    task automatic defaults();
        foreach (mem[i]) mem[i] = 8'h00;
        mem[0] = 8'h18;
        mem[8'h14] = 8'h05;
        lsb = 1'b0;
    endtask : defaults
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h00 && (d[5] || d[2])) begin
            defaults();
        end else begin
            mem[a] = d;
            if (a == 8'h00) lsb = d[6];
        end
    endtask : put
    initial begin
        defaults();
        cnt = 0;
        drv = 1'b0;
        sd_o = 1'b0;
    end
    // frame survives select high between bytes: only a full count ends it
    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            if (cnt < 16) ins = lsb ? {sdio_i, ins[15:1]} : {ins[14:0], sdio_i};
            else sh = lsb ? {sdio_i, sh[7:1]} : {sh[6:0], sdio_i};
            cnt++;
            if (cnt == 16) begin
                nb = ins[14:13] + 1;
                adr = ins[7:0];
            end else if (cnt > 16 && cnt % 8 == 0) begin
                if (!ins[15]) put(adr, sh);
                adr = lsb ? adr + 8'h01 : adr - 8'h01;
                if ((cnt - 16) / 8 == nb) cnt = 0;
            end
        end
    end
    always @(negedge sclk_i) begin
        // select may move at this very edge: its gating is left to drv_o
        drv <= ins[15] && cnt >= 16;
        sd_o <= lsb ? mem[adr][(cnt - 16) % 8] : mem[adr][7 - (cnt - 16) % 8];
    end
    assign drv_o = drv && !cs_n_i;
endmodule : acsp_dev_model
`default_nettype wire

// ### tb_acsp_host.sv
// bench for the host end of the configuration port
// assumes the device model and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_acsp_host;
    import acsp_pkg::*;
    logic        clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, hold_off_i = 0, last = 0;
    logic [2:0]  reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, rv;
    wire  [31:0] reg_rdata_o;
    wire         cs_n, sclk, sd, oe, drv, dsd;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    // released wire toggles so a stale level never reads as data
    wire sdio = oe ? sd : (drv ? dsd : ~last);
    always #50 clk_sys_i = ~clk_sys_i;
    acsp_host #(.STALL_LEN(2)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hold_off_i(hold_off_i),
        .chip_select_n_o(cs_n), .serial_clock_o(sclk), .serial_data_o(sd),
        .serial_data_oe_o(oe), .serial_data_i(sdio));
    acsp_dev_model dev_u (.cs_n_i(cs_n), .sclk_i(sclk), .sdio_i(sdio), .drv_o(drv), .sd_o(dsd));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys_i) begin
        cyc++;
        last <= sdio;
        if (oe === 1'b1 && drv === 1'b1) chk("pin_clash", 0, 1);
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end
    always @(posedge sclk) if (cs_n !== 1'b0) chk("clock_unselected", 0, 1);
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic go(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(HR_ADDR, a);
        wr(HR_WDATA, d);
        wr(HR_CTRL, c);
    endtask : go
    task automatic fin();
        rv = 0;
        for (int i = 0; i < 500 && rv[STS_DONE] !== 1'b1; i++) rd(HR_STATUS, rv);
        chk("done", 32'h2, rv & 32'h2);
        wr(HR_STATUS, 32'h6);
    endtask : fin
    task automatic run(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        go(a, d, c);
        fin();
    endtask : run
    task automatic t_defaults();
        run(0, 0, 32'h3);
        rd(HR_RDATA, rv);
        chk("cfg_default", 32'h18, rv);
        run(32'h14, 0, 32'h3);
        rd(HR_RDATA, rv);
        chk("fmt_default", 32'h05, rv);
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_stream();
        run(32'h09, 32'h3CA5, 32'h5);
        chk("mem09", 32'hA5, dev_u.mem[9]);
        chk("mem08", 32'h3C, dev_u.mem[8]);
        run(32'h09, 0, 32'h17);
        rd(HR_RDATA, rv);
        chk("stall_read", 32'h3CA5, rv);
        run(32'h0F, 32'h44332211, 32'h1D);
        chk("mem0f", 32'h11, dev_u.mem[15]);
        chk("mem0c_burst", 32'h44, dev_u.mem[12]);
        run(32'h0F, 0, 32'h0F);
        rd(HR_RDATA, rv);
        chk("burst_read", 32'h44332211, rv);
        rd(HR_CTRL, rv);
        chk("ctrl_back", 32'h0E, rv);
        rd(HR_ADDR, rv);
        chk("addr_back", 32'h0F, rv);
        $display("test stream done");
    endtask : t_stream
    task automatic t_refuse();
        go(32'h13, 32'h77, 32'h1);
        rd(HR_STATUS, rv);
        chk("open_refused", 32'h4, rv & 32'h5);
        wr(HR_STATUS, 32'h6);
        go(32'h0C, 32'h11, 32'h1);
        wr(HR_CTRL, 32'h3);
        rd(HR_STATUS, rv);
        chk("busy_refused", 32'h4, rv & 32'h4);
        fin();
        chk("mem0c", 32'h11, dev_u.mem[12]);
        chk("mem13", 32'h00, dev_u.mem[19]);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_order();
        run(0, 32'h40, 32'h1);
        chk("cfg_mirror", 32'h5A, dev_u.mem[0]);
        rd(HR_STATUS, rv);
        chk("lsb_flag", 32'h8, rv & 32'h8);
        run(32'h0A, 32'h2211, 32'h5);
        chk("mem0a", 32'h11, dev_u.mem[10]);
        chk("mem0b", 32'h22, dev_u.mem[11]);
        run(0, 32'h20, 32'h1);
        chk("soft_reset", 32'h18, dev_u.mem[0]);
        rd(HR_STATUS, rv);
        chk("msb_again", 32'h0, rv & 32'h8);
        $display("test order done");
    endtask : t_order
    task automatic t_quiet();
        @(posedge clk_sys_i);
        hold_off_i <= 1'b1;
        go(32'h0D, 32'h5E, 32'h1);
        repeat (20) @(posedge clk_sys_i);
        chk("quiet_select", 32'h1, cs_n);
        hold_off_i <= 1'b0;
        fin();
        chk("mem0d", 32'h5E, dev_u.mem[13]);
        $display("test quiet done");
    endtask : t_quiet
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_defaults();
        t_stream();
        t_refuse();
        t_order();
        t_quiet();
        wrap_up();
    end
endmodule : tb_acsp_host
`default_nettype wire
